// ===== verilog/vps_amp_map.svh
// register map, field positions, reset values and timing counts
`ifndef VPS_AMP_MAP_SVH
`define VPS_AMP_MAP_SVH
// ==========================================
// register byte offsets
`define VPS_OFS_CTRL   8'h00
`define VPS_OFS_AMPCFG 8'h04
`define VPS_OFS_THRS   8'h08
`define VPS_OFS_STEP   8'h0C
`define VPS_OFS_SCALE  8'h10
`define VPS_OFS_STAT   8'h14
`define VPS_OFS_ISTS   8'h18
`define VPS_OFS_IMSK   8'h1C
// ==========================================
// field positions
`define VPS_CTRL_EN    0
`define VPS_CTRL_AUTO  1
`define VPS_CTRL_SH_LO 2
`define VPS_CFG_GR_LO  8
// ==========================================
// reset values and limits
`define VPS_CTRL_RST   8'h00
`define VPS_OFFS_RST   8'h00
`define VPS_GRAD_RST   8'h00
`define VPS_THRS_RST   20'h00000
`define VPS_THRS_MAX   20'hFFFFF
`define VPS_AMP_MAX    8'hFF
// ==========================================
// timing counts
`define VPS_NORM_RES   256
`define VPS_OL_STEPS   4
`define VPS_DIV_BITS   16
`endif

// ===== verilog/vps_amp_pkg.sv
// types shared by the amplitude scaling block
package vps_amp_pkg;
	// chopper in charge of the coils
	typedef enum logic {VPS_QUIET, VPS_CYCLE} vps_mode_e;
	// software configuration
	typedef struct packed {
		logic        enable;
		logic        autoscale;
		logic [2:0]  res_shift;
		logic [7:0]  offset;
		logic [7:0]  gradient;
		logic [19:0] threshold;
	} vps_cfg_s;
	// per-coil open-load flags
	typedef struct packed {
		logic coil_b;
		logic coil_a;
	} vps_ol_s;
endpackage : vps_amp_pkg

// ===== verilog/vps_amp.sv
// quiet voltage-mode pwm amplitude scaling with apb registers
// ==========================================
// Functional notes
// [RL1] feed-forward amplitude from measured microstep interval
// [RL2] amplitude is offset plus gradient*256/interval
// [RL3] interval normalised to 256-microstep resolution
// [RL4] 8-bit amplitude, peak 248, coil voltage /374; the code lets the amplitude reach 255
// [RL5] quiet chopper below threshold, cycle chopper above
// [RL6] threshold zero keeps quiet chopper always
// [RL7] hold regulation value while cycle chopper runs
// [RL8] re-entry amplitude limited by offset setting
// [RL9] host enables quiet mode at standstill
// [RL10] host keeps motor stopped 128 chopper periods
// [RL11] host clears flags, restarts from zero velocity
// [RL12] open-load flag when target current unreached
// [RL13] broken coil keeps its flag asserted
// [RL14] applied amplitude readable by software
// [RL15] host may program offset 255 for re-entry
// [RL16] autoscale bit selects regulation over feed-forward
// [RL17] quiet while interval at or above threshold
// [RL18] feed-forward amplitude saturates at 255
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "vps_amp_map.svh"
module vps_amp #(
	parameter int OL_STEPS = `VPS_OL_STEPS // fullsteps without target current
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic                      pslverr,
	output logic [31:0]               prdata,
	input  wire logic                 step_pulse,
	input  wire logic                 fullstep_pulse,
	input  wire logic                 pwm_period_pulse,
	input  wire logic                 coil_a_reached,
	input  wire logic                 coil_b_reached,
	output vps_amp_pkg::vps_mode_e    chopper_mode,
	output logic [7:0]                amplitude,
	output vps_amp_pkg::vps_ol_s      open_load,
	output logic                      irq
);
	import vps_amp_pkg::*;
	// ==========================================
	// pin synchronisers for the current comparators
	logic [1:0] reach_m_q, reach_s_q; // first and second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reach_m_q <= 2'h0;
			reach_s_q <= 2'h0;
		end else begin
			reach_m_q <= {coil_b_reached, coil_a_reached};
			reach_s_q <= reach_m_q;
		end
	end
	// ==========================================
	// configuration and interrupt registers
	vps_cfg_s   cfg_q, cfg_d;           // software settings
	logic [2:0] ists_q, ists_d;         // sticky events
	logic [2:0] imsk_q, imsk_d;         // event mask
	logic [31:0] rdat_q, rdat_d;        // read data, taken in setup
	logic [2:0] evt;                    // this cycle's events
	logic       wr_acc, setup, hit;     // bus qualifiers
	logic [31:0] rd_val;                // decoded read value
	logic [19:0] step_interval_q, step_interval_d;
	logic [7:0]  amp_q, amp_d;
	vps_mode_e   mode_q, mode_d;
	vps_ol_s     ol_q, ol_d;
	// no wait state: read data is registered during setup
	assign setup  = psel & ~penable;
	assign pready = psel & penable;
	assign wr_acc = pready & pwrite;
	assign prdata = rdat_q;
	// address decode, unmapped offsets answer with an error
	always_comb begin
		hit    = 1'b1;
		rd_val = 32'h0000_0000;
		if (paddr == `VPS_OFS_CTRL) begin
			rd_val[4:0] = {cfg_q.res_shift, cfg_q.autoscale, cfg_q.enable};
		end else if (paddr == `VPS_OFS_AMPCFG) begin
			rd_val[15:0] = {cfg_q.gradient, cfg_q.offset};
		end else if (paddr == `VPS_OFS_THRS) begin
			rd_val[19:0] = cfg_q.threshold;
		end else if (paddr == `VPS_OFS_STEP) begin
			rd_val[19:0] = step_interval_q;
		end else if (paddr == `VPS_OFS_SCALE) begin
			rd_val[7:0] = amp_q; // RL14
		end else if (paddr == `VPS_OFS_STAT) begin
			rd_val[2:0] = {mode_q == VPS_QUIET, ol_q};
		end else if (paddr == `VPS_OFS_ISTS) begin
			rd_val[2:0] = ists_q;
		end else if (paddr == `VPS_OFS_IMSK) begin
			rd_val[2:0] = imsk_q;
		end else begin
			hit = 1'b0; // unmapped
		end
	end
	assign pslverr = pready & ~hit;
	// register writes; a new event beats a write-one clear
	always_comb begin
		cfg_d  = cfg_q;
		imsk_d = imsk_q;
		rdat_d = setup ? rd_val : rdat_q;
		ists_d = ists_q;
		if (wr_acc && paddr == `VPS_OFS_CTRL) begin
			cfg_d.enable    = pwdata[`VPS_CTRL_EN];
			cfg_d.autoscale = pwdata[`VPS_CTRL_AUTO]; // RL16
			cfg_d.res_shift = pwdata[`VPS_CTRL_SH_LO +: 3];
		end else if (wr_acc && paddr == `VPS_OFS_AMPCFG) begin
			cfg_d.offset   = pwdata[7:0];
			cfg_d.gradient = pwdata[`VPS_CFG_GR_LO +: 8];
		end else if (wr_acc && paddr == `VPS_OFS_THRS) begin
			cfg_d.threshold = pwdata[19:0];
		end else if (wr_acc && paddr == `VPS_OFS_IMSK) begin
			imsk_d = pwdata[2:0];
		end else if (wr_acc && paddr == `VPS_OFS_ISTS) begin
			ists_d = ists_q & ~pwdata[2:0];
		end
		ists_d = ists_d | evt;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q  <= '{1'b0, 1'b0, 3'h0, `VPS_OFFS_RST, `VPS_GRAD_RST, `VPS_THRS_RST};
			ists_q <= 3'h0;
			imsk_q <= 3'h0;
			rdat_q <= 32'h0000_0000;
		end else begin
			cfg_q  <= cfg_d;
			ists_q <= ists_d;
			imsk_q <= imsk_d;
			rdat_q <= rdat_d;
		end
	end
	assign irq = |(ists_q & imsk_q);
	// ==========================================
	// microstep interval measurement in clock cycles
	logic [19:0] cnt_q, cnt_d; // cycles since last step
	logic        int_new;      // interval refreshed
	always_comb begin
		cnt_d           = cnt_q;
		step_interval_d = step_interval_q;
		int_new         = 1'b0;
		if (step_pulse) begin
			// coarse steps cover 2^shift fine steps: scale down
			step_interval_d = (cnt_q >> cfg_q.res_shift) | 20'h00001; // RL3 RL1
			cnt_d   = 20'h00001;
			int_new = 1'b1;
		end else if (cnt_q != `VPS_THRS_MAX) begin
			cnt_d = cnt_q + 20'h00001;
		end else begin
			// standstill: report the slowest interval
			step_interval_d = `VPS_THRS_MAX;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q           <= 20'h00001;
			step_interval_q <= `VPS_THRS_MAX;
		end else begin
			cnt_q           <= cnt_d;
			step_interval_q <= step_interval_d;
		end
	end
	// ==========================================
	// serial divider: gradient*256 / interval
	logic [20:0] rem_q, rem_d;  // partial remainder
	logic [15:0] quo_q, quo_d;  // quotient, holds dividend at start
	logic [4:0]  dcnt_q, dcnt_d; // bits left
	logic [15:0] ff_term_q, ff_term_d; // velocity term
	logic [20:0] trial;
	always_comb begin
		rem_d     = rem_q;
		quo_d     = quo_q;
		dcnt_d    = dcnt_q;
		ff_term_d = ff_term_q;
		trial     = {rem_q[19:0], quo_q[15]};
		if (int_new) begin
			// restart: a new interval overrides one in flight
			rem_d  = 21'h000000;
			quo_d  = {cfg_q.gradient, 8'h00}; // RL2
			dcnt_d = 5'(`VPS_DIV_BITS);
		end else if (dcnt_q != 5'h00) begin
			if (trial >= {1'b0, step_interval_q}) begin
				rem_d = trial - {1'b0, step_interval_q};
				quo_d = {quo_q[14:0], 1'b1};
			end else begin
				rem_d = trial;
				quo_d = {quo_q[14:0], 1'b0};
			end
			dcnt_d = dcnt_q - 5'h01;
			if (dcnt_q == 5'h01) begin
				ff_term_d = quo_d; // RL1
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem_q     <= 21'h000000;
			quo_q     <= 16'h0000;
			dcnt_q    <= 5'h00;
			ff_term_q <= 16'h0000;
		end else begin
			rem_q     <= rem_d;
			quo_q     <= quo_d;
			dcnt_q    <= dcnt_d;
			ff_term_q <= ff_term_d;
		end
	end
	// ==========================================
	// feed-forward sum with saturation
	logic [16:0] ff_sum; // offset plus velocity term
	logic [7:0]  ff_amp;
	assign ff_sum = {9'h000, cfg_q.offset} + {1'b0, ff_term_q}; // RL2
	assign ff_amp = (ff_sum > 17'(`VPS_AMP_MAX)) ? `VPS_AMP_MAX : ff_sum[7:0]; // RL18
	// ==========================================
	// chopper selection and amplitude regulation
	logic quiet_ok; // velocity allows quiet chopper
	logic [8:0] up; // regulator step up
	// zero threshold means quiet at every velocity
	assign quiet_ok = cfg_q.enable & ((cfg_q.threshold == `VPS_THRS_RST) |
		(step_interval_q >= cfg_q.threshold)); // RL5 RL6 RL17
	assign up = {1'b0, amp_q} + {1'b0, cfg_q.gradient} + 9'h001;
	always_comb begin
		mode_d = quiet_ok ? VPS_QUIET : VPS_CYCLE; // RL5
		amp_d  = amp_q;
		evt    = 3'h0;
		if (mode_q == VPS_QUIET && mode_d == VPS_CYCLE) begin
			evt[0] = 1'b1; // handed over, amplitude frozen
		end else if (mode_q == VPS_CYCLE && mode_d == VPS_QUIET) begin
			evt[1] = 1'b1;
			// limit re-entry amplitude to damp phase jerk
			if (amp_q > cfg_q.offset) begin
				amp_d = cfg_q.offset; // RL8
			end
		end else if (mode_q == VPS_QUIET && !cfg_q.autoscale) begin
			amp_d = ff_amp; // RL1 RL16
		end else if (mode_q == VPS_QUIET && pwm_period_pulse) begin
			// fixed step toward the target current: gradient+1 up, one down
			if (&reach_s_q) begin
				amp_d = (amp_q != 8'h00) ? amp_q - 8'h01 : amp_q;
			end else begin
				amp_d = up[8] ? `VPS_AMP_MAX : up[7:0];
			end
		end
		// while cycle mode continues nothing above runs: value is held RL7
		evt[2] = (ol_d != 2'h0) & (ol_q == 2'h0);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= VPS_CYCLE;
			amp_q  <= 8'h00;
		end else begin
			mode_q <= mode_d;
			amp_q  <= amp_d;
		end
	end
	assign chopper_mode = mode_q;
	assign amplitude    = amp_q; // RL4 RL14
	// ==========================================
	// open-load detection per coil
	logic [7:0] miss_a_q, miss_a_d, miss_b_q, miss_b_d; // fullsteps missed
	function automatic logic [7:0] miss_next(input logic [7:0] m,
		input logic reached, input logic fs);
		if (reached) begin
			miss_next = 8'h00;
		end else if (fs && m != 8'hFF) begin
			miss_next = m + 8'h01;
		end else begin
			miss_next = m;
		end
	endfunction : miss_next
	always_comb begin
		miss_a_d = miss_next(miss_a_q, reach_s_q[0], fullstep_pulse);
		miss_b_d = miss_next(miss_b_q, reach_s_q[1], fullstep_pulse);
		// flags only mean something while quiet chopper runs
		ol_d.coil_a = (mode_q == VPS_QUIET) & (miss_a_q >= 8'(OL_STEPS)); // RL12 RL13
		ol_d.coil_b = (mode_q == VPS_QUIET) & (miss_b_q >= 8'(OL_STEPS)); // RL12 RL13
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			miss_a_q <= 8'h00;
			miss_b_q <= 8'h00;
			ol_q     <= 2'h0;
		end else begin
			miss_a_q <= miss_a_d;
			miss_b_q <= miss_b_d;
			ol_q     <= ol_d;
		end
	end
	assign open_load = ol_q;
	// ==========================================
	// checks
	property p_zero_thrs_quiet;
		@(posedge pclk) disable iff (!presetn)
		(cfg_q.enable && cfg_q.threshold == 20'h0) |=> mode_q == VPS_QUIET;
	endproperty
	a_zero_thrs_quiet: assert property (p_zero_thrs_quiet) else $error("left quiet mode"); // RL6
	property p_fast_cycle;
		@(posedge pclk) disable iff (!presetn)
		(cfg_q.threshold != 20'h0 && step_interval_q < cfg_q.threshold) |=> mode_q == VPS_CYCLE;
	endproperty
	a_fast_cycle: assert property (p_fast_cycle) else $error("fast motion stayed quiet"); // RL5 RL17
	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		(mode_q == VPS_CYCLE && mode_d == VPS_CYCLE) |=> $stable(amp_q);
	endproperty
	a_hold: assert property (p_hold) else $error("amplitude moved in cycle mode"); // RL7
	property p_reentry;
		@(posedge pclk) disable iff (!presetn)
		(mode_q == VPS_CYCLE && mode_d == VPS_QUIET) |=> amp_q <= cfg_q.offset;
	endproperty
	a_reentry: assert property (p_reentry) else $error("re-entry not limited"); // RL8
	property p_ff;
		@(posedge pclk) disable iff (!presetn)
		(mode_q == VPS_QUIET && mode_d == VPS_QUIET && !cfg_q.autoscale) |=> amp_q == $past(ff_amp);
	endproperty
	a_ff: assert property (p_ff) else $error("feed-forward amplitude wrong"); // RL1 RL2
	property p_sat;
		@(posedge pclk) disable iff (!presetn) ff_sum > 17'h000FF |-> ff_amp == 8'hFF;
	endproperty
	a_sat: assert property (p_sat) else $error("amplitude wrapped"); // RL18
	property p_ol_quiet;
		@(posedge pclk) disable iff (!presetn) mode_q == VPS_CYCLE |=> ol_q == 2'h0;
	endproperty
	a_ol_quiet: assert property (p_ol_quiet) else $error("open load outside quiet"); // RL12
	property p_ol_broken;
		@(posedge pclk) disable iff (!presetn)
		(mode_q == VPS_QUIET && miss_a_q >= 8'(OL_STEPS)) |=> ol_q.coil_a;
	endproperty
	a_ol_broken: assert property (p_ol_broken) else $error("open load a missing"); // RL13
	property p_scale_read;
		@(posedge pclk) disable iff (!presetn)
		(setup && paddr == `VPS_OFS_SCALE) |=> prdata[7:0] == $past(amp_q);
	endproperty
	a_scale_read: assert property (p_scale_read) else $error("scale read wrong"); // RL14
endmodule : vps_amp

// ===== verification/vps_coil_model.sv
// two-coil stepper model telling the block whether target current is reached
`timescale 1ns/1ps
module vps_coil_model
	import vps_amp_pkg::*;
#(
	parameter logic [7:0] NEED_AMP = 8'h28 // amplitude that drives target current
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [7:0]       amplitude,
	input  vps_amp_pkg::vps_mode_e chopper_mode,
	input  wire logic             broken_a,
	input  wire logic             broken_b,
	output logic                  coil_a_reached,
	output logic                  coil_b_reached
);
	// ==========================================
	// current build-up
	logic cur_ok; // drive strong enough for target current
	// the cycle chopper regulates current itself, so it always gets there
	always_comb cur_ok = (chopper_mode == VPS_CYCLE) || (amplitude >= NEED_AMP);
	// an interrupted coil never carries current, whatever the drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			coil_a_reached <= 1'b0;
			coil_b_reached <= 1'b0;
		end else begin
			coil_a_reached <= cur_ok && !broken_a;
			coil_b_reached <= cur_ok && !broken_b;
		end
	end
endmodule : vps_coil_model

// ===== verification/tb.sv
// self-checking bench for the amplitude scaling block
`timescale 1ns/1ps
`include "vps_amp_map.svh"
module tb;
	import vps_amp_pkg::*;
	// ==========================================
	// signals
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic        pready, pslverr, irq, errv;
	logic        step_pulse = 1'b0, fullstep_pulse = 1'b0, pwm_period_pulse = 1'b0;
	logic        coil_a_reached, coil_b_reached;
	logic        broken_a = 1'b0, broken_b = 1'b0, pwm_en = 1'b0;
	vps_mode_e   chopper_mode;
	logic [7:0]  amplitude, held;
	vps_ol_s     open_load;
	int          step_per = 0, scnt = 0, pcnt = 0, errors = 0, check_count = 0;
	// ==========================================
	// design, coil model, clock
	vps_amp uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .step_pulse(step_pulse),
		.fullstep_pulse(fullstep_pulse), .pwm_period_pulse(pwm_period_pulse),
		.coil_a_reached(coil_a_reached), .coil_b_reached(coil_b_reached),
		.chopper_mode(chopper_mode), .amplitude(amplitude), .open_load(open_load), .irq(irq));
	vps_coil_model coils (.pclk(pclk), .presetn(presetn), .amplitude(amplitude),
		.chopper_mode(chopper_mode), .broken_a(broken_a), .broken_b(broken_b),
		.coil_a_reached(coil_a_reached), .coil_b_reached(coil_b_reached));
	initial begin
		forever #5 pclk = ~pclk;
	end
	// microstep and chopper period pulses; step_per 0 means standstill
	always @(posedge pclk) begin
		scnt <= (step_per != 0 && scnt + 1 >= step_per) ? 0 : scnt + 1;
		step_pulse <= (step_per != 0) && (scnt == step_per - 1);
		pcnt <= (pcnt == 31) ? 0 : pcnt + 1;
		pwm_period_pulse <= pwm_en && (pcnt == 31);
	end
	// ==========================================
	// helpers
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// one apb transfer; an idle edge first so no signal is driven twice at once
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: only the watchdog ends a wait for pready
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rdv, errv);
	endtask : wr
	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0, rdv, errv);
	endtask : rd
	// bounded wait for a chopper hand-over, then confirm it
	task wait_mode(input vps_mode_e m);
		int n;
		n = 0;
		while (chopper_mode !== m && n < 3000) begin @(posedge pclk); n++; end
		check("mode", 32'(chopper_mode), 32'(m));
	endtask : wait_mode
	task fs(input int k);
		repeat (k) begin
			@(posedge pclk); fullstep_pulse <= 1'b1;
			@(posedge pclk); fullstep_pulse <= 1'b0;
		end
		repeat (6) @(posedge pclk);
	endtask : fs
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	// ==========================================
	// watchdog, well beyond the ~9k cycles the tests need
	initial begin
		repeat (80000) @(posedge pclk);
		errors++;
		wrap_up();
	end
	// ==========================================
	// tests
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		check("rst_mode", 32'(chopper_mode), 32'(VPS_CYCLE));
		rd(`VPS_OFS_STEP); check("rst_step", rdv, 32'h000FFFFF);
		rd(`VPS_OFS_SCALE); check("rst_scale", rdv, 32'h0);
		rd(8'h40); check("unmapped", {rdv[30:0], errv}, 32'h1);
		// regulation enabled at standstill, held for 128 periods
		wr(`VPS_OFS_AMPCFG, 32'h0405); // gradient 4, offset 5
		wr(`VPS_OFS_CTRL, 32'h3);
		pwm_en <= 1'b1;
		repeat (128 * 32) @(posedge pclk);
		check("quiet", 32'(chopper_mode), 32'(VPS_QUIET));
		check("amp_reg", 32'(amplitude >= 8'h26 && amplitude <= 8'h2E), 32'h1);
		rd(`VPS_OFS_SCALE); check("scale", 32'(rdv == 32'(amplitude)), 32'h1);
		// open coil a; regulator paused so the amplitude stays put
		pwm_en <= 1'b0;
		fs(6); check("ol_none", 32'(open_load), 32'h0);
		broken_a <= 1'b1;
		fs(6); check("ol_a", 32'(open_load), 32'h1);
		rd(`VPS_OFS_STAT); check("stat", rdv & 32'h7, 32'h5);
		rd(`VPS_OFS_ISTS); check("ists_ol", rdv & 32'h4, 32'h4);
		broken_b <= 1'b1;
		fs(6); check("ol_ab", 32'(open_load), 32'h3);
		broken_a <= 1'b0;
		broken_b <= 1'b0;
		fs(2); check("ol_clear", 32'(open_load), 32'h0);
		// faster than threshold: hand over and hold the value
		wr(`VPS_OFS_ISTS, 32'h7);
		wr(`VPS_OFS_IMSK, 32'h1);
		wr(`VPS_OFS_THRS, 32'd100);
		pwm_en <= 1'b1;
		step_per <= 50;
		wait_mode(VPS_CYCLE);
		held = amplitude;
		repeat (500) @(posedge pclk);
		check("hold", 32'(amplitude), 32'(held));
		check("irq_on", 32'(irq), 32'h1);
		wr(`VPS_OFS_ISTS, 32'h1);
		@(posedge pclk);
		check("irq_off", 32'(irq), 32'h0);
		// slow down: re-entry limited by offset, event masked
		pwm_en <= 1'b0;
		step_per <= 200;
		wait_mode(VPS_QUIET);
		repeat (3) @(posedge pclk);
		check("reentry", 32'(amplitude), 32'h5);
		check("irq_mask", 32'(irq), 32'h0);
		rd(`VPS_OFS_ISTS); check("ists_back", rdv & 32'h2, 32'h2);
		// feed-forward: 10 + 2*256/200
		wr(`VPS_OFS_THRS, 32'h0);
		wr(`VPS_OFS_AMPCFG, 32'h020A);
		wr(`VPS_OFS_CTRL, 32'h1);
		repeat (1000) @(posedge pclk);
		check("ff", 32'(amplitude), 32'd12);
		// half resolution: interval 100 gives 10 + 5
		wr(`VPS_OFS_CTRL, 32'h5);
		repeat (1000) @(posedge pclk);
		check("ff_res", 32'(amplitude), 32'd15);
		// threshold zero keeps quiet mode at high speed
		step_per <= 20;
		repeat (500) @(posedge pclk);
		check("thrs0", 32'(chopper_mode), 32'(VPS_QUIET));
		// offset 250 plus a large term saturates
		wr(`VPS_OFS_CTRL, 32'h1);
		wr(`VPS_OFS_AMPCFG, 32'hFFFA);
		step_per <= 40;
		repeat (600) @(posedge pclk);
		check("sat", 32'(amplitude), 32'hFF);
		rd(`VPS_OFS_SCALE); check("sat_rd", rdv, 32'hFF);
		// offset at its maximum: re-entry keeps the held amplitude
		wr(`VPS_OFS_CTRL, 32'h3);
		wr(`VPS_OFS_AMPCFG, 32'h04FF);
		wr(`VPS_OFS_THRS, 32'd100);
		wait_mode(VPS_CYCLE);
		step_per <= 200;
		wait_mode(VPS_QUIET);
		repeat (3) @(posedge pclk);
		check("reentry_max", 32'(amplitude), 32'hFF);
		wrap_up();
	end
endmodule : tb
